// file: pps_pkg.sv
// Constants, field positions and carrier types of the parallel port register set
package pps_pkg;

   // ****************************************************************
   // Register addresses on the two chip selects
   // ****************************************************************
   localparam logic [2:0] PP_ADDR_DATA    = 3'h0;  // Data port, or command FIFO port in ECP mode
   localparam logic [2:0] PP_ADDR_STATUS  = 3'h1;
   localparam logic [2:0] PP_ADDR_CONTROL = 3'h2;
   localparam logic [2:0] PP_ADDR_ASTRB   = 3'h3;  // Address strobe port; 4 to 7 are the data strobe port
   localparam logic [2:0] EC_ADDR_FIFO    = 3'h0;  // Data FIFO port, or capability A in configuration mode
   localparam logic [2:0] EC_ADDR_CAPB    = 3'h1;
   localparam logic [2:0] EC_ADDR_EXTCTL  = 3'h2;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int ST_BUSY    = 7;
   localparam int ST_PRINT   = 2;
   localparam int ST_TIMEOUT = 0;
   localparam int CT_DIR     = 5;
   localparam int CT_ACK_IRQ = 4;
   localparam int CT_SEL_IN  = 3;
   localparam int CT_INIT    = 2;
   localparam int CT_AUTOFD  = 1;
   localparam int CT_STROBE  = 0;
   localparam int EC_MODE_LSB   = 5;
   localparam int EC_FAULT_MASK = 4;
   localparam int EC_DMA_EN     = 3;
   localparam int EC_SVC_DIS    = 2;

   // ****************************************************************
   // Reset and constant field values
   // ****************************************************************
   localparam logic [7:0] CONTROL_RESET  = 8'hc0;  // Reserved bits 7 and 6 sit at 1
   localparam logic [5:0] EXTCTL_RESET   = 6'h01;  // Standard mode, service interrupts disabled
   localparam logic       PRINT_RESET    = 1'h1;
   localparam logic [3:0] CAPA_RESERVED  = 4'hf;
   localparam logic [2:0] CAPB_IRQ_SEL   = 3'h1;
   localparam logic [2:0] CAPB_DMA_SEL   = 3'h3;
   localparam logic       CAPB_PACKING   = 1'h0;

   // ****************************************************************
   // Timing and sizes
   // ****************************************************************
   localparam int CLK_PERIOD_PS  = 8000;
   localparam int EPP_TIMEOUT_NS = 10000;
   localparam int EPP_TIMEOUT_CYC = (EPP_TIMEOUT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int STB_WIDTH_NS   = 1000;
   localparam int STB_WIDTH_CYC  = (STB_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int FIFO_DEPTH     = 16;
   localparam int SVC_THRESHOLD  = 12;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [2:0] {
      MODE_STD    = 3'b000,
      MODE_BIDI   = 3'b001,
      MODE_PFIFO  = 3'b010,
      MODE_ECP    = 3'b011,
      MODE_EPP    = 3'b100,
      MODE_RSVD   = 3'b101,
      MODE_TEST   = 3'b110,
      MODE_CONFIG = 3'b111
   } pps_mode_t;

   // Peripheral status inputs, pin levels
   typedef struct packed {
      logic busy;
      logic ack;
      logic paper_error_flag;
      logic select_flag;
      logic fault;
   } pps_pins_in_t;

   // Control outputs, 1 means the line is driven to its active level
   typedef struct packed {
      logic strobe_drive;
      logic autofd_drive;
      logic init_drive;
      logic select_in_drive;
   } pps_pins_out_t;

   // One FIFO entry: command tag and byte
   typedef struct packed {
      logic       cmd;
      logic [7:0] data;
   } pps_word_t;

endpackage

// file: pps_fifo.sv
// Tagged transfer FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module pps_fifo
#(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16,
   parameter int CW    = $clog2(DEPTH + 1)
)
(
   input  wire logic             i_sys_clk,
   input  wire logic             i_reset,
   input  wire logic             i_flush,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic [WIDTH-1:0]      o_out_data,
   output logic [CW-1:0]         o_count,
   output logic                  o_full,
   output logic                  o_empty
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_ptr_r;
   logic [PW-1:0]    rd_ptr_r;
   logic [CW-1:0]    count_r;
   wire              push;
   wire              pop;

   // ****************************************************************
   // Flags from occupancy count
   // ****************************************************************
   assign o_full      = (count_r == CW'(DEPTH));
   assign o_empty     = (count_r == '0);
   assign o_in_ready  = ~o_full;
   assign o_out_valid = ~o_empty;
   assign o_out_data  = mem[rd_ptr_r];
   assign o_count     = count_r;
   assign push        = i_in_valid & o_in_ready & ~i_flush;
   assign pop         = i_out_ready & o_out_valid & ~i_flush;

   // Pointers and count; flush drops everything held
   always_ff @(posedge i_sys_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end
      else if (i_flush)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
         if (pop)
            rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
         count_r <= count_r + CW'(push) - CW'(pop);
      end
   end

   // Storage array
   always_ff @(posedge i_sys_clk)
   begin
      if (push)
         mem[wr_ptr_r] <= i_in_data;
   end
endmodule
`default_nettype wire

// file: pps_regs.sv
// Parallel port register set with transfer engines and tagged FIFO
// Summary of operation
// - Command port writes enter the FIFO tagged as command bytes.
// - Status bit 7 reads the inverse of the busy input.
// - Status bits 6..3 mirror ack, paper, select, fault; bit 1 reads 0.
// - Print flag clears on ack rising edge, sets on a status read without ack rising edge in that cycle.
// - In EPP mode a 10 us cycle timeout sets bit 0; status writes clear it.
// - Control bits 7 and 6 are reserved and hold 1.
// - Direction bit ignored in standard and parallel FIFO modes; 1 floats data lines.
// - Control bit 4 passes an interrupt on ack rising edge.
// - Control bits 3,1,0 drive select-in, autofeed, strobe; bit 2 low drives init.
// - EPP mode address port access runs an address strobe cycle.
// - EPP mode data port access runs a data strobe cycle.
// - Forward data port writes or DMA enter the FIFO tagged as data.
// - With direction 1 in ECP mode bytes are fetched from peripheral by handshake.
// - Capability A reads implementation code high, all ones low.
// - Capability B bit 7 reads 0, no packing support.
// - Capability B bit 6 reads the interrupt line level.
// - Capability B bits 5..3 read 001, bits 2..0 read 011.
// - Extended control bits 7..5 select the operating mode.
// - In ECP mode bit 4 low enables the fault falling edge interrupt.
// - Bit 3 enables DMA; requests start once service disable is 0.
// - Service disable bit 2 at 1 blocks DMA requests and service interrupts.
// - Read-only bits 1 and 0 show FIFO full and empty.
`timescale 1ns/10ps
`default_nettype none
module pps_regs
   import pps_pkg::*;
#(
   parameter int         DEPTH     = FIFO_DEPTH,
   parameter logic [3:0] IMPL_CODE = 4'h5,              // Arbitrary value
   parameter int         TMO_CYC   = EPP_TIMEOUT_CYC,
   parameter int         CW        = $clog2(DEPTH + 1)
)
(
   input  wire logic          i_sys_clk,
   input  wire logic          i_reset,
   input  wire logic          i_pp_cs,
   input  wire logic          i_ecp_cs,
   input  wire logic [2:0]    i_addr,
   input  wire logic          i_rd,
   input  wire logic          i_wr,
   input  wire logic [7:0]    i_wdata,
   output logic [7:0]         o_rdata,
   input  wire logic          i_dma_ack,
   input  wire logic          i_dma_tc,
   output logic               o_dma_req,
   output logic               o_irq,
   input  wire pps_pins_in_t  i_pins,
   output pps_pins_out_t      o_pins,
   input  wire logic [7:0]    i_pd,
   output logic [7:0]         o_pd,
   output logic               o_pd_oe
);
   typedef enum logic [2:0] {
      ENG_IDLE     = 3'b000,
      ENG_FWD_STB  = 3'b001,
      ENG_FWD_REL  = 3'b010,
      ENG_REV_WAIT = 3'b011,
      ENG_REV_HOLD = 3'b100,
      ENG_EPP      = 3'b101
   } pps_eng_t;

   // ****************************************************************
   // State
   // ****************************************************************
   logic [7:0]    control_r;
   logic [5:0]    extctl_r;
   logic [7:0]    data_r;
   logic [7:0]    epp_rd_r;
   logic          print_r;
   logic          timeout_r;
   logic          ack_prev_r;
   logic          fault_prev_r;
   logic          svc_cond_prev_r;
   pps_eng_t      eng_r;
   pps_eng_t      eng_nxt;
   logic [15:0]   cnt_r;
   logic [7:0]    eng_data_r;
   logic          eng_cmd_r;
   logic          eng_write_r;
   logic          eng_astrb_r;
   logic [7:0]    rdata_r;
   logic          dma_req_r;
   logic          irq_r;
   pps_pins_out_t pins_r;
   logic [7:0]    pd_r;
   logic          pd_oe_r;

   // FIFO side
   pps_word_t     fifo_in;
   pps_word_t     fifo_out;
   logic          fifo_in_ready;
   logic          fifo_out_valid;
   logic [CW-1:0] fifo_count;
   logic          fifo_full;
   logic          fifo_empty;

   // ****************************************************************
   // Access decoding
   // ****************************************************************
   wire pps_mode_t mode = pps_mode_t'(extctl_r[5:3]);
   wire svc_dis      = extctl_r[EC_SVC_DIS - 2];
   wire dma_en       = extctl_r[EC_DMA_EN - 2];
   wire fault_mask   = extctl_r[EC_FAULT_MASK - 2];
   wire mode_ecp     = (mode == MODE_ECP);
   wire mode_test    = (mode == MODE_TEST);
   wire fifo_mode    = mode_ecp | (mode == MODE_PFIFO) | mode_test;
   wire dir_eff      = control_r[CT_DIR] & ~((mode == MODE_STD) | (mode == MODE_PFIFO));
   wire pp_rd        = i_pp_cs & i_rd;
   wire pp_wr        = i_pp_cs & i_wr;
   wire ec_rd        = i_ecp_cs & i_rd;
   wire ec_wr        = i_ecp_cs & i_wr;
   wire status_rd    = pp_rd & (i_addr == PP_ADDR_STATUS);
   wire status_wr    = pp_wr & (i_addr == PP_ADDR_STATUS);
   wire control_wr   = pp_wr & (i_addr == PP_ADDR_CONTROL);
   wire extctl_wr    = ec_wr & (i_addr == EC_ADDR_EXTCTL);
   wire data_wr      = pp_wr & (i_addr == PP_ADDR_DATA) & ((mode == MODE_STD) | (mode == MODE_BIDI));
   wire cmd_push     = pp_wr & (i_addr == PP_ADDR_DATA) & mode_ecp & ~dir_eff;
   wire fifo_port    = (i_addr == EC_ADDR_FIFO) & fifo_mode;
   wire data_push    = ((ec_wr & fifo_port) | (i_dma_ack & i_wr)) & (mode_test | ~dir_eff);
   wire host_pop     = ((ec_rd & fifo_port) | (i_dma_ack & i_rd)) & (mode_test | (mode_ecp & dir_eff));
   wire epp_access   = (mode == MODE_EPP) & i_pp_cs & (i_rd | i_wr) & (i_addr >= PP_ADDR_ASTRB);
   wire ack_rise     = i_pins.ack & ~ack_prev_r;
   wire fault_fall   = ~i_pins.fault & fault_prev_r;
   wire tc_hit       = i_dma_ack & i_dma_tc & dma_en;
   wire dma_dir      = mode_test ? control_r[CT_DIR] : dir_eff;

   // ****************************************************************
   // FIFO write and read selection
   // ****************************************************************
   wire eng_push = (eng_r == ENG_REV_WAIT) & mode_ecp & dir_eff & ~i_pins.ack & fifo_in_ready;
   wire eng_pop  = (eng_r == ENG_IDLE) & ~epp_access & fifo_out_valid & ~dir_eff
                   & (mode_ecp | ((mode == MODE_PFIFO) & ~i_pins.busy));
   assign fifo_in.cmd  = eng_push ? ~i_pins.busy : cmd_push;
   assign fifo_in.data = eng_push ? i_pd : i_wdata;

   pps_fifo
   #(
      .WIDTH ($bits(pps_word_t)),
      .DEPTH (DEPTH),
      .CW    (CW)
   )
   u_fifo
   (
      .i_sys_clk   (i_sys_clk),
      .i_reset     (i_reset),
      .i_flush     (~fifo_mode),
      .i_in_valid  (eng_push | cmd_push | data_push),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (fifo_in),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (eng_pop | host_pop),
      .o_out_data  (fifo_out),
      .o_count     (fifo_count),
      .o_full      (fifo_full),
      .o_empty     (fifo_empty)
   );

   // ****************************************************************
   // Read data selection
   // ****************************************************************
   wire [7:0] status_val  = {~i_pins.busy, i_pins.ack, i_pins.paper_error_flag,
                             i_pins.select_flag, i_pins.fault, print_r, 1'b0, timeout_r};
   wire [7:0] capa_val    = {IMPL_CODE, CAPA_RESERVED};
   wire [7:0] capb_val    = {CAPB_PACKING, irq_r, CAPB_IRQ_SEL, CAPB_DMA_SEL};
   wire [7:0] extctl_val  = {extctl_r, fifo_full, fifo_empty};
   wire [7:0] pp_val      = (i_addr == PP_ADDR_DATA)    ? i_pd :
                            (i_addr == PP_ADDR_STATUS)  ? status_val :
                            (i_addr == PP_ADDR_CONTROL) ? control_r :
                            (mode == MODE_EPP)          ? epp_rd_r : 8'h00;
   wire [7:0] ec_val      = (i_addr == EC_ADDR_EXTCTL) ? extctl_val :
                            (mode == MODE_CONFIG & i_addr == EC_ADDR_FIFO) ? capa_val :
                            (mode == MODE_CONFIG & i_addr == EC_ADDR_CAPB) ? capb_val :
                            host_pop ? fifo_out.data : 8'h00;
   wire [7:0] rdata_nxt   = (i_dma_ack & i_rd) ? fifo_out.data :
                            pp_rd ? pp_val : ec_rd ? ec_val : rdata_r;

   // ****************************************************************
   // Interrupt and DMA request terms
   // ****************************************************************
   wire svc_cond = fifo_mode & ~svc_dis & ~dma_en &
                   (dma_dir ? (fifo_count >= CW'(SVC_THRESHOLD))
                            : (fifo_count <= CW'(DEPTH - SVC_THRESHOLD)));
   wire irq_nxt  = (ack_rise & control_r[CT_ACK_IRQ])
                 | (mode_ecp & ~fault_mask & fault_fall)
                 | (~svc_dis & (tc_hit | (svc_cond & ~svc_cond_prev_r)));
   wire dma_req_nxt = dma_en & ~svc_dis & fifo_mode & ~tc_hit &
                      (dma_dir ? ~fifo_empty : ~fifo_full);

   // ****************************************************************
   // Transfer engine next state
   // ****************************************************************
   always_comb
   begin
      eng_nxt = eng_r;
      unique case (eng_r)
         ENG_IDLE:
         begin
            if (epp_access)
               eng_nxt = ENG_EPP;
            else if (eng_pop)
               eng_nxt = ENG_FWD_STB;
            else if (mode_ecp & dir_eff)
               eng_nxt = ENG_REV_WAIT;
         end
         ENG_FWD_STB:
         begin
            if (~fifo_mode)
               eng_nxt = ENG_IDLE;
            else if (mode_ecp ? i_pins.busy : (cnt_r >= 16'(STB_WIDTH_CYC - 1)))
               eng_nxt = ENG_FWD_REL;
         end
         ENG_FWD_REL:
            if (~fifo_mode | ~i_pins.busy)
               eng_nxt = ENG_IDLE;
         ENG_REV_WAIT:
         begin
            if (~(mode_ecp & dir_eff))
               eng_nxt = ENG_IDLE;
            else if (eng_push)
               eng_nxt = ENG_REV_HOLD;
         end
         ENG_REV_HOLD:
            if (i_pins.ack | ~mode_ecp)
               eng_nxt = ENG_IDLE;
         ENG_EPP:
            if (i_pins.busy | (cnt_r >= 16'(TMO_CYC - 1)))
               eng_nxt = ENG_IDLE;
         default:
            eng_nxt = ENG_IDLE;
      endcase
   end

   // ****************************************************************
   // Pin drive selection
   // ****************************************************************
   wire           fwd_busy = (eng_r == ENG_FWD_STB) | (eng_r == ENG_FWD_REL);
   wire           in_epp   = (eng_r == ENG_EPP);
   pps_pins_out_t pins_nxt;
   assign pins_nxt.strobe_drive    = control_r[CT_STROBE] | (eng_r == ENG_FWD_STB)
                                   | (in_epp & eng_write_r);
   assign pins_nxt.autofd_drive    = control_r[CT_AUTOFD] | (fwd_busy & eng_cmd_r)
                                   | (eng_r == ENG_REV_HOLD) | (in_epp & ~eng_astrb_r);
   assign pins_nxt.init_drive      = ~control_r[CT_INIT];
   assign pins_nxt.select_in_drive = control_r[CT_SEL_IN] | (in_epp & eng_astrb_r);
   wire [7:0] pd_nxt    = (fwd_busy | in_epp) ? eng_data_r : data_r;
   wire       pd_oe_nxt = ~dir_eff & ~(in_epp & ~eng_write_r);

   // ****************************************************************
   // Software registers
   // ****************************************************************
   always_ff @(posedge i_sys_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         control_r <= CONTROL_RESET;
         extctl_r  <= EXTCTL_RESET;
         data_r    <= 8'h00;
      end
      else
      begin
         if (control_wr)
            control_r <= {CONTROL_RESET[7:6], i_wdata[5:0]};
         if (extctl_wr)
            extctl_r <= i_wdata[7:2];
         if (tc_hit)
            extctl_r[EC_SVC_DIS - 2] <= 1'b1;
         if (data_wr)
            data_r <= i_wdata;
      end
   end

   // Status flags; hardware events win over software in the same cycle
   always_ff @(posedge i_sys_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         print_r   <= PRINT_RESET;
         timeout_r <= 1'b0;
      end
      else
      begin
         if (ack_rise)
            print_r <= 1'b0;
         else if (status_rd)
            print_r <= 1'b1;
         if (in_epp & ~i_pins.busy & (cnt_r >= 16'(TMO_CYC - 1)))
            timeout_r <= 1'b1;
         else if (status_wr)
            timeout_r <= 1'b0;
      end
   end

   // Edge history of peripheral inputs and of the service condition
   always_ff @(posedge i_sys_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         ack_prev_r      <= 1'b0;
         fault_prev_r    <= 1'b0;
         svc_cond_prev_r <= 1'b0;
      end
      else
      begin
         ack_prev_r      <= i_pins.ack;
         fault_prev_r    <= i_pins.fault;
         svc_cond_prev_r <= svc_cond;
      end
   end

   // ****************************************************************
   // Transfer engine registers
   // ****************************************************************
   always_ff @(posedge i_sys_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         eng_r       <= ENG_IDLE;
         cnt_r       <= 16'h0000;
         eng_data_r  <= 8'h00;
         eng_cmd_r   <= 1'b0;
         eng_write_r <= 1'b0;
         eng_astrb_r <= 1'b0;
         epp_rd_r    <= 8'h00;
      end
      else
      begin
         eng_r <= eng_nxt;
         cnt_r <= (eng_nxt == eng_r) ? cnt_r + 16'h0001 : 16'h0000;
         if ((eng_r == ENG_IDLE) & epp_access)
         begin
            eng_write_r <= i_wr;
            eng_astrb_r <= (i_addr == PP_ADDR_ASTRB);
            eng_data_r  <= i_wdata;
         end
         else if (eng_pop)
         begin
            eng_data_r <= fifo_out.data;
            eng_cmd_r  <= fifo_out.cmd;
         end
         if (in_epp & i_pins.busy & ~eng_write_r)
            epp_rd_r <= i_pd;
      end
   end

   // ****************************************************************
   // Registered outputs
   // ****************************************************************
   always_ff @(posedge i_sys_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         rdata_r   <= 8'h00;
         dma_req_r <= 1'b0;
         irq_r     <= 1'b0;
         pins_r    <= '0;
         pd_r      <= 8'h00;
         pd_oe_r   <= 1'b1;
      end
      else
      begin
         rdata_r   <= rdata_nxt;
         dma_req_r <= dma_req_nxt;
         irq_r     <= irq_nxt;
         pins_r    <= pins_nxt;
         pd_r      <= pd_nxt;
         pd_oe_r   <= pd_oe_nxt;
      end
   end

   assign o_rdata   = rdata_r;
   assign o_dma_req = dma_req_r;
   assign o_irq     = irq_r;
   assign o_pins    = pins_r;
   assign o_pd      = pd_r;
   assign o_pd_oe   = pd_oe_r;
endmodule
`default_nettype wire

// file: pps_regs_asserts.sv
// Port level checker of the parallel port register set
`timescale 1ns/10ps
`default_nettype none
module pps_chk
   import pps_pkg::*;
(
   input wire logic         i_sys_clk,
   input wire logic         i_reset,
   input wire logic         i_pp_cs,
   input wire logic         i_ecp_cs,
   input wire logic [2:0]   i_addr,
   input wire logic         i_rd,
   input wire logic         i_wr,
   input wire logic [7:0]   i_wdata,
   input wire logic [7:0]   o_rdata,
   input wire pps_pins_in_t i_pins,
   input wire logic         o_irq,
   input wire logic         o_pd_oe
);
   logic [2:0] mode_r;
   wire        st_rd = i_pp_cs && i_rd && i_addr == PP_ADDR_STATUS;
   wire        ct_ac = i_pp_cs && i_addr == PP_ADDR_CONTROL;
   wire        cf_rd = i_ecp_cs && i_rd && mode_r == MODE_CONFIG && i_addr == EC_ADDR_CAPB;
   wire        ex_rd = i_ecp_cs && i_rd && i_addr == EC_ADDR_EXTCTL;
   // Mode field as last written by the host
   always_ff @(posedge i_sys_clk or posedge i_reset)
      if (i_reset) mode_r <= 3'h0;
      else if (i_ecp_cs && i_wr && i_addr == EC_ADDR_EXTCTL) mode_r <= i_wdata[7:5];
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);
   sequence s_st;
      st_rd && $stable(i_pins);
   endsequence
   a_busy_inv: assert property (s_st |=> o_rdata[7] == !$past(i_pins.busy)) else $error("busy");
   a_st_pins: assert property (s_st |=> o_rdata[6:3] == $past(i_pins[3:0]) && !o_rdata[1])
      else $error("pins");
   a_print_set: assert property (st_rd && !i_pins.ack && !$past(i_pins.ack) ##1 (!i_pins.ack)[*2]
      ##1 st_rd && !i_pins.ack |=> o_rdata[ST_PRINT]) else $error("print");
   a_ctl_rsvd: assert property (ct_ac && i_rd |=> o_rdata[7:6] == 2'b11) else $error("rsvd");
   a_capb_const: assert property (cf_rd |=> !o_rdata[7] && o_rdata[5:0] == 6'h0b) else $error("capb");
   a_capb_irq: assert property (cf_rd |=> o_rdata[6] == $past(o_irq)) else $error("irq lvl");
   a_ext_empty: assert property (ex_rd && mode_r == MODE_STD && $stable(mode_r) |=> o_rdata[1:0] == 2'b01)
      else $error("flags");
   a_dir_float: assert property (ct_ac && i_wr && i_wdata[CT_DIR] && mode_r == MODE_BIDI |-> ##[1:2] !o_pd_oe)
      else $error("dir");
   c_print: cover property (st_rd ##3 st_rd);
   c_irq: cover property (o_irq);
   c_float: cover property (!o_pd_oe);
endmodule
bind pps_regs pps_chk chk_u (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_pp_cs(i_pp_cs), .i_ecp_cs(i_ecp_cs),
   .i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_pins(i_pins),
   .o_irq(o_irq), .o_pd_oe(o_pd_oe));
`default_nettype wire

// file: pps_periph.sv
// Peripheral model answering host strobes with busy
`timescale 1ns/10ps
`default_nettype none
module pps_periph
   import pps_pkg::*;
(
   input wire logic          i_clk,
   input wire logic          i_stall,
   input wire logic          i_ecp,
   input wire logic [3:0]    i_lv,
   input wire pps_pins_out_t i_drv,
   output pps_pins_in_t      o_pins
);
   logic busy_r = 1'b0;
   // Busy follows strobe, and outside ECP also autofeed or select-in, a cycle later unless stalled
   always @(posedge i_clk)
      busy_r <= !i_stall && (i_drv.strobe_drive || !i_ecp && (i_drv.autofd_drive || i_drv.select_in_drive));
   assign o_pins = {busy_r, i_lv};
endmodule
`default_nettype wire

// file: test_parallel_port_register_set.sv
// Self-checking bench of the parallel port register set
`timescale 1ns/10ps
`default_nettype none
`define CK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; $display("MISMATCH t=%0t %h", $time, g); end end
module test_parallel_port_register_set;
   import pps_pkg::*;
   typedef struct packed {logic [7:0] c; logic [3:0] l; logic [7:0] s;} pps_row_t;
   pps_row_t rows [4] = '{'{8'h00, 4'ha, 8'hd0}, '{8'h01, 4'h5, 8'h28}, '{8'h0b, 4'hf, 8'h78}, '{8'h34, 4'h0, 8'h80}};
   logic clk = 0, rst = 1, pcs = 0, ecs = 0, rd = 0, wr = 0, stall = 0, ecp = 0, irq, oe, dreq;
   logic [2:0] addr = 3'h0;
   logic [7:0] wd = 8'h00, rdata, pd;
   logic [3:0] lv = 4'h0;
   pps_pins_in_t pin;
   pps_pins_out_t drv;
   int error_cnt = 0, n_compared = 0, cyc = 0, irq_n = 0, k;
   pps_regs #(.IMPL_CODE(4'h9), .TMO_CYC(20)) dut_u (.i_sys_clk(clk), .i_reset(rst), .i_pp_cs(pcs), .i_ecp_cs(ecs),
      .i_addr(addr), .i_rd(rd), .i_wr(wr), .i_wdata(wd), .o_rdata(rdata), .i_dma_ack(1'b0), .i_dma_tc(1'b0),
      .o_dma_req(dreq), .o_irq(irq), .i_pins(pin), .o_pins(drv), .i_pd(oe ? pd : 8'h3c), .o_pd(pd), .o_pd_oe(oe));
   pps_periph per_u (.i_clk(clk), .i_stall(stall), .i_ecp(ecp), .i_lv(lv), .i_drv(drv), .o_pins(pin));
   task automatic end_sim(input int extra);
      error_cnt += extra;
      $display("errors %0d compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // One host access: strobe for one cycle, then settle
   task automatic acc(input logic e, input logic w, input logic [2:0] a, input logic [7:0] d);
      @(negedge clk);
      {ecs, pcs, addr, rd, wr, wd} = {e, !e, a, !w, w, d};
      @(negedge clk);
      {ecs, pcs, rd, wr} = 4'h0;
      @(negedge clk);
   endtask
   always #4 clk = ~clk;
   // Interrupt pulse count and hang limit
   always @(negedge clk)
   begin
      irq_n += int'(irq === 1'b1);
      cyc++;
      if (cyc == 20000)
         end_sim(1);
   end
   initial
   begin
      repeat (8) @(negedge clk);
      rst = 0;
      acc(0, 0, PP_ADDR_CONTROL, 8'h00);
      `CK(rdata, 8'hc0)
      `CK(drv, 4'h2)
      acc(1, 0, EC_ADDR_EXTCTL, 8'h00);
      `CK(rdata, 8'h05)
      acc(0, 0, PP_ADDR_STATUS, 8'h00);
      `CK(rdata & 8'h05, 8'h04)
      foreach (rows[i])
      begin
         lv = rows[i].l;
         acc(0, 1, PP_ADDR_CONTROL, rows[i].c);
         acc(0, 0, PP_ADDR_CONTROL, 8'h00);
         `CK(rdata, {2'b11, rows[i].c[5:0]})
         `CK(drv, {rows[i].c[0], rows[i].c[1], !rows[i].c[2], rows[i].c[3]})
         acc(0, 0, PP_ADDR_STATUS, 8'h00);
         `CK(rdata & 8'hfa, rows[i].s)
         `CK(oe, 1'b1)
      end
      `CK(irq_n, 0)
      lv = 4'h8;
      repeat (3) @(negedge clk);
      lv = 4'h0;
      repeat (3) @(negedge clk);
      `CK(irq_n, 1)
      acc(0, 0, PP_ADDR_STATUS, 8'h00);
      `CK(rdata[ST_PRINT], 1'b0)
      acc(0, 0, PP_ADDR_STATUS, 8'h00);
      `CK(rdata[ST_PRINT], 1'b1)
      acc(1, 1, EC_ADDR_EXTCTL, {MODE_BIDI, 5'h04});
      acc(0, 1, PP_ADDR_CONTROL, 8'h20);
      `CK(oe, 1'b0)
      acc(0, 1, PP_ADDR_CONTROL, 8'h00);
      acc(1, 1, EC_ADDR_EXTCTL, {MODE_CONFIG, 5'h04});
      acc(1, 0, EC_ADDR_FIFO, 8'h00);
      `CK(rdata, 8'h9f)
      acc(1, 0, EC_ADDR_CAPB, 8'h00);
      `CK(rdata, 8'h0b)
      acc(1, 0, EC_ADDR_EXTCTL, 8'h00);
      `CK(rdata, 8'he5)
      acc(1, 1, EC_ADDR_EXTCTL, {MODE_STD, 5'h04});
      acc(1, 1, EC_ADDR_EXTCTL, {MODE_EPP, 5'h04});
      stall = 1;
      for (k = 3; k < 5; k++)
      begin
         acc(0, 1, k[2:0], 8'h11);
         `CK(k == 3 ? drv.select_in_drive : drv.autofd_drive, 1'b1)
         repeat (30) @(negedge clk);
         acc(0, 0, PP_ADDR_STATUS, 8'h00);
         `CK(rdata[ST_TIMEOUT], 1'b1)
         acc(0, 1, PP_ADDR_STATUS, 8'h00);
         acc(0, 0, PP_ADDR_STATUS, 8'h00);
         `CK(rdata[ST_TIMEOUT], 1'b0)
      end
      acc(1, 1, EC_ADDR_EXTCTL, {MODE_STD, 5'h04});
      acc(1, 1, EC_ADDR_EXTCTL, {MODE_ECP, 5'h04});
      ecp = 1;
      acc(0, 1, PP_ADDR_DATA, 8'ha5);
      repeat (3) @(negedge clk);
      `CK({pd, drv.autofd_drive}, {8'ha5, 1'b1})
      for (k = 0; k < 16; k++)
         acc(1, 1, EC_ADDR_FIFO, k[7:0]);
      acc(1, 0, EC_ADDR_EXTCTL, 8'h00);
      `CK(rdata[1:0], 2'b10)
      stall = 0;
      for (k = 0; k < 99 && !(drv.strobe_drive && pd === 8'h00); k++)
         @(negedge clk);
      `CK({pd, drv}, {8'h00, 4'ha})
      repeat (300) @(negedge clk);
      acc(1, 0, EC_ADDR_EXTCTL, 8'h00);
      `CK(rdata[1:0], 2'b01)
      lv = 4'h1;
      acc(1, 1, EC_ADDR_EXTCTL, {MODE_ECP, 5'h08});
      `CK(dreq, 1'b1)
      lv = 4'h0;
      acc(1, 1, EC_ADDR_EXTCTL, {MODE_ECP, 5'h0c});
      `CK({dreq, irq_n}, {1'b0, 32'd2})
      acc(0, 1, PP_ADDR_CONTROL, 8'h20);
      acc(1, 0, EC_ADDR_FIFO, 8'h00);
      `CK({rdata, oe}, {8'h3c, 1'b0})
      end_sim(0);
   end
endmodule
`default_nettype wire
